//--- common/sbg_pkg.sv
// shared constants, types and helpers of the secure bitstream mode gate
// assumes an apb slave on ref_clk and a load link on config_data_clock
// What this block does
// [RULE1] no key stored: accept only plain bitstreams, refuse encrypted ones
// [RULE2] volatile key, tamper clear: accept encrypted and plain board-test
// [RULE3] one-time key, tamper clear: accept encrypted and plain board-test
// [RULE4] tamper set: accept only encrypted over decrypting schemes
// [RULE5] tamper set never blocks a later permitted reload
// [RULE6] volatile key erased: refuse every encrypted bitstream
// [RULE7] programmer reprograms an erased key in volatile mode, tamper clear
// [RULE8] host drives data clock four times word rate in parallel+decrypt
// [RULE9] other decrypting schemes take one word per clock, time unchanged
// [RULE10] decryption only in parallel, serial and self-driven schemes
// [RULE11] test port loads accept only plain bitstreams
// [RULE12] plain bitstreams go through the path that bypasses decryption
// [RULE13] decrypt each portion first, then decompress, then configure
// [RULE14] decryption combines with decompression and remote update freely
// [RULE15] key is 256 bits and held before encrypted data is taken
// [RULE16] refused type or scheme aborts load and flags error to host
package sbg_pkg;
    // apb byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_KEY = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;

    // control fields
    localparam int CTRL_KEY_LO = 0;
    localparam int CTRL_TAMPER = 2;
    localparam int CTRL_ERASE = 3;

    // status fields
    localparam int STAT_FULL = 0;
    localparam int STAT_ERASED = 1;
    localparam int STAT_LAST_OK = 2;
    localparam int STAT_LAST_ENC = 3;
    localparam int STAT_OK_LO = 8;
    localparam int STAT_BAD_LO = 16;

    localparam int KEY_BITS = 256;
    localparam int BUS_W = 32;
    localparam int KEY_WORDS = KEY_BITS / BUS_W;
    localparam int KEY_IDX_W = $clog2(KEY_WORDS);
    localparam int CNT_W = 8;
    localparam int PAR_CLK_RATIO = 4;

    // stored key kind
    localparam logic [1:0] KEY_NONE = 2'h0;
    localparam logic [1:0] KEY_VOLATILE = 2'h1;
    localparam logic [1:0] KEY_OTP = 2'h2;

    // load scheme strap codes
    localparam logic [2:0] SCH_PARALLEL = 3'h0;
    localparam logic [2:0] SCH_SERIAL = 3'h1;
    localparam logic [2:0] SCH_SELF = 3'h2;
    localparam logic [2:0] SCH_QUICK_SELF = 3'h3;
    localparam logic [2:0] SCH_REMOTE_SELF = 3'h4;
    localparam logic [2:0] SCH_REMOTE_QUICK = 3'h5;
    localparam logic [2:0] SCH_TEST_PORT = 3'h6;

    // header word bits
    localparam int HDR_ENC = 0;
    localparam int HDR_COMP = 1;

    typedef struct packed {
        logic enc_ok;
        logic plain_ok;
    } sbg_policy_t;

    typedef struct packed {
        logic [7:0] data;
        logic decrypt;
        logic decompress;
    } sbg_word_t;

    // schemes whose path includes the decryption engine
    function automatic logic scheme_decrypts(input logic [2:0] s);
        case (s)
            SCH_PARALLEL, SCH_SERIAL, SCH_SELF, SCH_QUICK_SELF,
            SCH_REMOTE_SELF, SCH_REMOTE_QUICK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
endpackage

//--- design/sbg_key_store.sv
// key word memory with a registered read port
// assumes one writer and one reader on the same clock
`timescale 1ns/1ps
module sbg_key_store #(
    parameter int WORDS = sbg_pkg::KEY_WORDS,
    parameter int W = sbg_pkg::BUS_W,
    parameter int IDX_W = sbg_pkg::KEY_IDX_W
) (
    // clock, reset and clock enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // write side
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [W-1:0] wr_data,
    // read side
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [WORDS];
    logic [W-1:0] rd_d;

    always_comb begin
        rd_d = mem[rd_idx];
    end

    always_ff @(posedge ref_clk) begin
        if (ce && wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= rd_d;
        end
    end
endmodule // sbg_key_store

//--- design/sbg_mode_gate.sv
// secure bitstream mode gate: apb policy registers and the load link gate
// assumes the header word opens every frame and straps are quasi-static
`timescale 1ns/1ps
module sbg_mode_gate #(
    parameter int CNT_W = sbg_pkg::CNT_W,
    parameter int RATIO = sbg_pkg::PAR_CLK_RATIO
) (
    // system
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // key to the decryption engine
    input wire logic [sbg_pkg::KEY_IDX_W-1:0] aes_key_idx,
    output logic [31:0] aes_key_word,
    // load link
    input wire logic config_data_clock,
    input wire logic [2:0] load_scheme,
    input wire logic cfg_frame,
    input wire logic cfg_valid,
    input wire logic [7:0] cfg_data,
    // towards decryption and decompression
    output sbg_pkg::sbg_word_t out_word,
    output logic out_valid,
    output logic cfg_error,
    output logic cfg_accepted
);
    localparam int KW = sbg_pkg::KEY_IDX_W;
    localparam int PW = $clog2(RATIO);

    // core domain state
    logic [1:0] key_type_q, key_type_d;
    logic tamper_q, tamper_d;
    logic erased_q, erased_d;
    logic full_q, full_d;
    logic [KW-1:0] wptr_q, wptr_d;
    logic [31:0] prdata_q, prdata_d;
    logic slverr_q, slverr_d;
    logic [CNT_W-1:0] ok_cnt_q, ok_cnt_d, bad_cnt_q, bad_cnt_d;
    logic last_ok_q, last_ok_d, last_enc_q, last_enc_d;
    logic [3:0] tog_sync_q;
    logic [1:0] res_m_q, res_s_q;
    logic key_wr;
    logic setup, wr_acc, decide_ev;
    sbg_pkg::sbg_policy_t pol_core;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = slverr_q;
    // one stage later than the result pair, so res_s_q is settled
    assign decide_ev = tog_sync_q[3] ^ tog_sync_q[2];

    always_comb begin
        key_type_d = key_type_q;
        tamper_d = tamper_q;
        erased_d = erased_q;
        full_d = full_q;
        wptr_d = wptr_q;
        key_wr = 1'b0;
        prdata_d = prdata_q;
        slverr_d = 1'b0;
        ok_cnt_d = ok_cnt_q;
        bad_cnt_d = bad_cnt_q;
        last_ok_d = last_ok_q;
        last_enc_d = last_enc_q;
        if (setup) begin
            prdata_d = '0;
            case (paddr)
                sbg_pkg::ADDR_CTRL: begin
                    prdata_d[sbg_pkg::CTRL_KEY_LO +: 2] = key_type_q;
                    prdata_d[sbg_pkg::CTRL_TAMPER] = tamper_q;
                end
                sbg_pkg::ADDR_KEY: prdata_d = '0;
                sbg_pkg::ADDR_STAT: begin
                    prdata_d[sbg_pkg::STAT_FULL] = full_q;
                    prdata_d[sbg_pkg::STAT_ERASED] = erased_q;
                    prdata_d[sbg_pkg::STAT_LAST_OK] = last_ok_q;
                    prdata_d[sbg_pkg::STAT_LAST_ENC] = last_enc_q;
                    prdata_d[sbg_pkg::STAT_OK_LO +: CNT_W] = ok_cnt_q;
                    prdata_d[sbg_pkg::STAT_BAD_LO +: CNT_W] = bad_cnt_q;
                end
                default: slverr_d = 1'b1;
            endcase
        end
        if (wr_acc && paddr == sbg_pkg::ADDR_CTRL) begin
            // a one-time key kind can never be changed again
            if (!tamper_q && key_type_q != sbg_pkg::KEY_OTP) begin
                key_type_d = pwdata[sbg_pkg::CTRL_KEY_LO +: 2];
            end
            // tamper is sticky and only means something with a key
            if (pwdata[sbg_pkg::CTRL_TAMPER] &&
                key_type_q != sbg_pkg::KEY_NONE) begin
                tamper_d = 1'b1;
            end
            if (pwdata[sbg_pkg::CTRL_ERASE] &&
                key_type_q == sbg_pkg::KEY_VOLATILE) begin
                erased_d = 1'b1; // [RULE6]
                full_d = 1'b0;
                wptr_d = '0;
            end
        end
        // key loading only while tamper is clear; an erased volatile key
        // is rebuilt this way [RULE7]
        if (wr_acc && paddr == sbg_pkg::ADDR_KEY && !tamper_q &&
            !full_q && key_type_q != sbg_pkg::KEY_NONE) begin
            key_wr = 1'b1;
            wptr_d = KW'(wptr_q + 1'b1);
            if (wptr_q == KW'(sbg_pkg::KEY_WORDS - 1)) begin
                full_d = 1'b1; // [RULE15]
                erased_d = 1'b0;
            end
        end
        if (decide_ev) begin
            last_ok_d = res_s_q[1];
            last_enc_d = res_s_q[0];
            if (res_s_q[1]) begin
                ok_cnt_d = CNT_W'(ok_cnt_q + 1'b1);
            end else begin
                bad_cnt_d = CNT_W'(bad_cnt_q + 1'b1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            key_type_q <= sbg_pkg::KEY_NONE;
            tamper_q <= 1'b0;
            erased_q <= 1'b0;
            full_q <= 1'b0;
            wptr_q <= '0;
            prdata_q <= '0;
            slverr_q <= 1'b0;
            ok_cnt_q <= '0;
            bad_cnt_q <= '0;
            last_ok_q <= 1'b0;
            last_enc_q <= 1'b0;
        end else if (ce) begin
            key_type_q <= key_type_d;
            tamper_q <= tamper_d;
            erased_q <= erased_d;
            full_q <= full_d;
            wptr_q <= wptr_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
            ok_cnt_q <= ok_cnt_d;
            bad_cnt_q <= bad_cnt_d;
            last_ok_q <= last_ok_d;
            last_enc_q <= last_enc_d;
        end
    end

    // policy handed to the link
    always_comb begin
        pol_core.enc_ok = key_type_q != sbg_pkg::KEY_NONE && full_q &&
            !erased_q; // [RULE1] [RULE6] [RULE15]
        pol_core.plain_ok = !tamper_q; // [RULE2] [RULE3] [RULE4] [RULE1]
    end

    sbg_key_store u_key (
        .ref_clk(ref_clk),
        .reset(reset),
        .ce(ce),
        .wr_en(key_wr),
        .wr_idx(wptr_q),
        .wr_data(pwdata),
        .rd_idx(aes_key_idx),
        .rd_data(aes_key_word)
    );

    // link domain
    typedef enum logic [1:0] {L_IDLE, L_HEAD, L_PASS, L_REFUSE} sbg_lst_t;
    sbg_lst_t lst_q, lst_d;
    logic lrst_m_q, lrst_q;
    sbg_pkg::sbg_policy_t pol_m_q, pol_q;
    logic [2:0] sch_m_q, sch_q;
    logic enc_q, enc_d, comp_q, comp_d;
    logic [PW-1:0] ph_q, ph_d;
    sbg_pkg::sbg_word_t ow_q, ow_d;
    logic ov_q, ov_d, err_q, err_d, acc_q, acc_d;
    logic tog_q, tog_d, rok_q, rok_d, renc_q, renc_d;
    logic hdr_ok, slow, take;

    always_ff @(posedge config_data_clock) begin
        lrst_m_q <= reset;
        lrst_q <= lrst_m_q;
        pol_m_q <= pol_core;
        pol_q <= pol_m_q;
        sch_m_q <= load_scheme;
        sch_q <= sch_m_q;
    end

    always_comb begin
        // test port carries no decryption, so encrypted is refused there
        hdr_ok = cfg_data[sbg_pkg::HDR_ENC] ?
            (pol_q.enc_ok && sbg_pkg::scheme_decrypts(sch_q)) : // [RULE10]
            pol_q.plain_ok; // [RULE11] [RULE4]
        if (cfg_data[sbg_pkg::HDR_COMP] &&
            sch_q == sbg_pkg::SCH_TEST_PORT) begin
            hdr_ok = 1'b0; // [RULE11]
        end
        // parallel with decryption or decompression takes every ratio-th
        // edge; all other schemes one word per edge [RULE8] [RULE9]
        slow = sch_q == sbg_pkg::SCH_PARALLEL && (enc_q || comp_q);
        take = cfg_valid && (!slow || ph_q == PW'(RATIO - 1));
    end

    always_comb begin
        lst_d = lst_q;
        enc_d = enc_q;
        comp_d = comp_q;
        ph_d = ph_q;
        ow_d = ow_q;
        ov_d = 1'b0;
        err_d = err_q;
        acc_d = acc_q;
        tog_d = tog_q;
        rok_d = rok_q;
        renc_d = renc_q;
        case (lst_q)
            L_IDLE: begin
                if (cfg_frame) begin
                    // a new frame is always heard, tamper or not [RULE5]
                    lst_d = L_HEAD;
                    err_d = 1'b0;
                    acc_d = 1'b0;
                end
            end
            L_HEAD: begin
                if (cfg_valid) begin
                    enc_d = cfg_data[sbg_pkg::HDR_ENC];
                    comp_d = cfg_data[sbg_pkg::HDR_COMP];
                    ph_d = '0;
                    tog_d = !tog_q;
                    rok_d = hdr_ok;
                    renc_d = cfg_data[sbg_pkg::HDR_ENC];
                    if (hdr_ok) begin
                        lst_d = L_PASS;
                        acc_d = 1'b1;
                    end else begin
                        lst_d = L_REFUSE;
                        err_d = 1'b1; // [RULE16]
                    end
                end
            end
            L_PASS: begin
                if (cfg_valid) begin
                    ph_d = PW'(ph_q + 1'b1);
                end
                if (take) begin
                    ov_d = 1'b1;
                    ow_d.data = cfg_data;
                    // plain data skips decryption [RULE12]; both stages
                    // run decrypt first, then decompress [RULE13] [RULE14]
                    ow_d.decrypt = enc_q;
                    ow_d.decompress = comp_q;
                end
            end
            L_REFUSE: begin
                err_d = 1'b1; // [RULE16]
            end
            default: lst_d = L_IDLE;
        endcase
        if (!cfg_frame && lst_q != L_IDLE) begin
            lst_d = L_IDLE;
            ov_d = 1'b0;
        end
    end

    always_ff @(posedge config_data_clock) begin
        if (lrst_q) begin
            lst_q <= L_IDLE;
            enc_q <= 1'b0;
            comp_q <= 1'b0;
            ph_q <= '0;
            ow_q <= '0;
            ov_q <= 1'b0;
            err_q <= 1'b0;
            acc_q <= 1'b0;
            tog_q <= 1'b0;
            rok_q <= 1'b0;
            renc_q <= 1'b0;
        end else begin
            lst_q <= lst_d;
            enc_q <= enc_d;
            comp_q <= comp_d;
            ph_q <= ph_d;
            ow_q <= ow_d;
            ov_q <= ov_d;
            err_q <= err_d;
            acc_q <= acc_d;
            tog_q <= tog_d;
            rok_q <= rok_d;
            renc_q <= renc_d;
        end
    end

    assign out_word = ow_q;
    assign out_valid = ov_q;
    assign cfg_error = err_q;
    assign cfg_accepted = acc_q;

    // decision event back to the core: toggle plus held result bits,
    // which stay still long after the toggle has crossed
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tog_sync_q <= '0;
            res_m_q <= '0;
            res_s_q <= '0;
        end else if (ce) begin
            tog_sync_q <= {tog_sync_q[2:0], tog_q};
            res_m_q <= {rok_q, renc_q};
            res_s_q <= res_m_q;
        end
    end
endmodule // sbg_mode_gate

//--- sim/sbg_host_model.sv
// behavioural configuration host driving the load link
// assumes one caller at a time; the link clock runs only inside calls
`timescale 1ns/1ps
module sbg_host_model (
    // load link
    output logic lclk,
    output logic [2:0] scheme,
    output logic frame,
    output logic valid,
    output logic [7:0] data
);
    initial begin
        lclk = 1'b0;
        scheme = 3'h1;
        frame = 1'b0;
        valid = 1'b0;
        data = 8'h5a;
    end

    // odd half periods, but the 160 ns period is four ref_clk periods, so the phase against ref_clk stays fixed
    task automatic tick(input logic f, input logic v, input logic [7:0] d);
        #73 lclk = 1'b1;
        frame <= f;
        valid <= v;
        data <= v ? d : ~data;
        #87 lclk = 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) tick(1'b0, 1'b0, 8'h00);
    endtask

    task automatic send(input logic [2:0] s, input logic [7:0] h,
                        input int n);
        int rep;
        rep = (s == sbg_pkg::SCH_PARALLEL && h[1:0] != 2'h0) ? 4 : 1;
        scheme = s;
        idle(3);
        tick(1'b1, 1'b0, 8'h00);
        tick(1'b1, 1'b1, h);
        for (int i = 0; i < n; i++)
            repeat (rep) tick(1'b1, 1'b1, 8'ha0 + 8'(i));
        repeat (2) tick(1'b1, 1'b0, 8'h00);
        idle(2);
    endtask
endmodule // sbg_host_model

//--- sim/sbg_mode_gate_monitor.sv
// port checker for the mode gate, bound into every instance
// assumes straps hold steady while a frame runs
`timescale 1ns/1ps
module sbg_mode_gate_monitor #(
    parameter int CNT_W = 8,
    parameter int RATIO = 4
) (
    // system and apb
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pslverr,
    // link
    input wire logic config_data_clock,
    input wire logic [2:0] load_scheme,
    input wire logic cfg_frame,
    input wire logic cfg_valid,
    input wire sbg_pkg::sbg_word_t out_word,
    input wire logic out_valid,
    input wire logic cfg_error,
    input wire logic cfg_accepted
);
    property p_excl;
        @(posedge config_data_clock) disable iff (reset)
        !(cfg_error && cfg_accepted);
    endproperty
    a_excl: assert property (p_excl)
        else $error("accept and error together");
    property p_fwd;
        @(posedge config_data_clock) disable iff (reset)
        out_valid |-> cfg_accepted && $past(cfg_valid);
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("word forwarded without acceptance");
    property p_tport;
        @(posedge config_data_clock) disable iff (reset)
        out_valid |-> !(out_word.decrypt &&
            load_scheme == sbg_pkg::SCH_TEST_PORT);
    endproperty
    a_tport: assert property (p_tport)
        else $error("decryption on test port");
    // host holds each word four edges, so pulses are four apart
    property p_pace;
        @(posedge config_data_clock) disable iff (reset)
        out_valid && load_scheme == sbg_pkg::SCH_PARALLEL &&
        (out_word.decrypt || out_word.decompress) |=> !out_valid [*3];
    endproperty
    a_pace: assert property (p_pace)
        else $error("parallel pacing broken");
    property p_rate;
        @(posedge config_data_clock) disable iff (reset)
        cfg_frame && cfg_valid && cfg_accepted &&
        load_scheme != sbg_pkg::SCH_PARALLEL |=> out_valid;
    endproperty
    a_rate: assert property (p_rate)
        else $error("serial word not forwarded");
    property p_acc;
        @(posedge config_data_clock) disable iff (reset)
        $rose(cfg_accepted) |-> $past(cfg_valid) && $past(cfg_frame);
    endproperty
    a_acc: assert property (p_acc)
        else $error("accept without header");
    property p_err;
        @(posedge config_data_clock) disable iff (reset)
        $rose(cfg_error) |-> $past(cfg_valid) && $past(cfg_frame);
    endproperty
    a_err: assert property (p_err)
        else $error("error without header");
    property p_unmap;
        @(posedge ref_clk) disable iff (reset)
        psel && penable && paddr > 12'h008 |-> pslverr;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped access not flagged");
endmodule // sbg_mode_gate_monitor

bind sbg_mode_gate sbg_mode_gate_monitor #(.CNT_W(CNT_W), .RATIO(RATIO))
    mon (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr),
    .config_data_clock(config_data_clock), .load_scheme(load_scheme),
    .cfg_frame(cfg_frame), .cfg_valid(cfg_valid), .out_word(out_word),
    .out_valid(out_valid), .cfg_error(cfg_error),
    .cfg_accepted(cfg_accepted)
);

//--- sim/tb.sv
// self-checking bench for the secure bitstream mode gate
// assumes the host model owns the link clock and framing
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [sbg_pkg::KEY_IDX_W-1:0] kidx = '0;
    logic [31:0] prdata, kword, rd;
    logic pready, pslverr, rerr, lclk, frm, vld, ov, err, acc;
    logic [2:0] sch;
    logic [7:0] dat;
    sbg_pkg::sbg_word_t ow, last_w;
    int miscompares = 0;
    int compares = 0;
    int nfwd = 0;
    int cyc = 0;

    initial forever #20 ref_clk = ~ref_clk;

    sbg_mode_gate dut (
        .ref_clk(ref_clk), .reset(reset), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aes_key_idx(kidx), .aes_key_word(kword),
        .config_data_clock(lclk), .load_scheme(sch), .cfg_frame(frm),
        .cfg_valid(vld), .cfg_data(dat), .out_word(ow),
        .out_valid(ov), .cfg_error(err), .cfg_accepted(acc)
    );
    sbg_host_model host (
        .lclk(lclk), .scheme(sch), .frame(frm), .valid(vld), .data(dat)
    );

    always @(posedge lclk) begin
        if (ov === 1'b1) begin
            nfwd++;
            last_w = ow;
        end
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fill_key(input logic [31:0] base);
        for (int i = 0; i < sbg_pkg::KEY_WORDS; i++)
            apb(1'b1, sbg_pkg::ADDR_KEY, base + 32'(i));
    endtask

    task automatic frame(input logic [2:0] s, input logic [7:0] h,
                         input int n, input logic ok);
        nfwd = 0;
        host.send(s, h, n);
        chk({30'h0, acc, err}, {30'h0, ok, !ok});
        chk(32'(nfwd), ok ? 32'(n) : 32'h0);
        if (ok)
            chk({22'h0, last_w}, {22'h0, 8'ha0 + 8'(n - 1), h[0], h[1]});
    endtask

    task automatic s_no_key();
        apb(1'b1, sbg_pkg::ADDR_CTRL, 32'h0);
        // a write while the clock enable is low must leave no trace
        ce <= 1'b0;
        apb(1'b1, sbg_pkg::ADDR_CTRL, 32'h1);
        ce <= 1'b1;
        apb(1'b0, sbg_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        frame(sbg_pkg::SCH_SERIAL, 8'h00, 2, 1'b1);
        frame(sbg_pkg::SCH_SERIAL, 8'h01, 2, 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, rerr}, 32'h1);
    endtask

    task automatic s_volatile();
        apb(1'b1, sbg_pkg::ADDR_CTRL, 32'h1);
        frame(sbg_pkg::SCH_SERIAL, 8'h01, 1, 1'b0);
        fill_key(32'h1000);
        apb(1'b0, sbg_pkg::ADDR_STAT, 32'h0);
        chk({31'h0, rd[sbg_pkg::STAT_FULL]}, 32'h1);
        kidx <= 3'h3;
        repeat (3) @(posedge ref_clk);
        chk(kword, 32'h1003);
        for (int s = 0; s < 6; s++)
            frame(3'(s), 8'h01, 2, 1'b1);
        frame(sbg_pkg::SCH_PARALLEL, 8'h03, 2, 1'b1);
        frame(sbg_pkg::SCH_TEST_PORT, 8'h01, 1, 1'b0);
        frame(sbg_pkg::SCH_TEST_PORT, 8'h02, 1, 1'b0);
        frame(sbg_pkg::SCH_TEST_PORT, 8'h00, 2, 1'b1);
        frame(sbg_pkg::SCH_SELF, 8'h00, 1, 1'b1);
    endtask

    task automatic s_erase();
        apb(1'b1, sbg_pkg::ADDR_CTRL, 32'h9);
        frame(sbg_pkg::SCH_SERIAL, 8'h01, 1, 1'b0);
        frame(sbg_pkg::SCH_SERIAL, 8'h00, 1, 1'b1);
        apb(1'b0, sbg_pkg::ADDR_STAT, 32'h0);
        chk({31'h0, rd[sbg_pkg::STAT_ERASED]}, 32'h1);
        apb(1'b1, sbg_pkg::ADDR_CTRL, 32'h1);
        fill_key(32'h2000);
        frame(sbg_pkg::SCH_REMOTE_QUICK, 8'h03, 2, 1'b1);
    endtask

    task automatic s_otp();
        apb(1'b1, sbg_pkg::ADDR_CTRL, 32'h2);
        frame(sbg_pkg::SCH_QUICK_SELF, 8'h01, 1, 1'b1);
        frame(sbg_pkg::SCH_QUICK_SELF, 8'h00, 1, 1'b1);
    endtask

    // tamper is sticky, so this runs last
    task automatic s_tamper();
        apb(1'b1, sbg_pkg::ADDR_CTRL, 32'h6);
        frame(sbg_pkg::SCH_SERIAL, 8'h00, 1, 1'b0);
        frame(sbg_pkg::SCH_TEST_PORT, 8'h01, 1, 1'b0);
        frame(sbg_pkg::SCH_SERIAL, 8'h01, 2, 1'b1);
        apb(1'b0, sbg_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h6);
        // 15 accepted, 7 refused, last one encrypted and accepted, key full
        apb(1'b0, sbg_pkg::ADDR_STAT, 32'h0);
        chk(rd, 32'h00070f0d);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // link edges during reset let the link side see it too
    initial begin
        host.idle(4);
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        s_no_key();
        s_volatile();
        s_erase();
        s_otp();
        s_tamper();
        tally_and_finish();
    end
endmodule // tb
